// *** logic/mif_chan_mon.sv ***
// Per-channel trip and zero-crossing watch for voltage and current samples.
// Assumes samples are absolute values and levels are stable between writes.
`timescale 1ns/1ps
module mif_chan_mon
	import mif_pkg::*;
#(
	parameter int CH = 3,
	parameter int W  = 16
) (
	input  wire logic                 ref_clk,
	input  wire logic                 sys_rst,
	input  wire logic                 sample_valid,
	input  wire logic [CH-1:0][W-1:0] volt_abs,
	input  wire logic [CH-1:0][W-1:0] curr_abs,
	input  wire logic [W-1:0]         low_level,
	input  wire logic [W-1:0]         high_level,
	input  wire logic [W-1:0]         curr_level,
	input  wire logic [CH-1:0]        zero_cross,
	input  wire logic                 cycle_start,
	input  wire logic [W-1:0]         zx_timeout,
	mif_evt_if.mon                    evt
);
	logic [CH-1:0]        above_reg;
	logic [CH-1:0]        hv_hit;
	logic [CH-1:0]        hi_hit;
	logic [CH-1:0]        zx_due;
	// Unpacked so each channel's process owns its own word
	logic [W-1:0]         zx_cnt_reg [CH];
	logic                 armed_reg;

	for (genvar c = 0; c < CH; c++) begin : g_ch
		assign hv_hit[c] = sample_valid && volt_abs[c] > high_level;
		assign hi_hit[c] = sample_valid && curr_abs[c] > curr_level;
		// Fires once when the count lands on the timeout; zero disables
		assign zx_due[c] = cycle_start && !zero_cross[c] && zx_timeout != '0
			&& zx_cnt_reg[c] == zx_timeout - 1'b1;

		always_ff @(posedge ref_clk) begin
			if (sys_rst)
				zx_cnt_reg[c] <= '0;
			else if (zero_cross[c])
				zx_cnt_reg[c] <= '0;
			else if (cycle_start && zx_cnt_reg[c] != zx_timeout)
				zx_cnt_reg[c] <= zx_cnt_reg[c] + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			above_reg         <= '0;
			armed_reg         <= 1'b0;
			evt.low_volt_hit  <= 1'b0;
			evt.high_volt_hit <= 1'b0;
			evt.high_curr_hit <= 1'b0;
			evt.zero_miss     <= 1'b0;
		end else begin
			evt.high_volt_hit <= |hv_hit;
			evt.high_curr_hit <= |hi_hit;
			evt.zero_miss     <= |zx_due;
			// First boundary only arms: no full cycle observed yet
			evt.low_volt_hit  <= cycle_start && armed_reg && !(&above_reg);
			if (cycle_start) begin
				armed_reg <= 1'b1;
				above_reg <= '0;
			end else begin
				for (int c = 0; c < CH; c++)
					if (sample_valid && volt_abs[c] > low_level)
						above_reg[c] <= 1'b1;
			end
		end
	end
endmodule // mif_chan_mon

// *** logic/mif_evt_if.sv ***
// Event carrier from the channel monitor to the flag core.
// Assumes both ends run on ref_clk; every signal is a one-cycle pulse.
`timescale 1ns/1ps
interface mif_evt_if;
	logic low_volt_hit;
	logic high_volt_hit;
	logic high_curr_hit;
	logic zero_miss;
	modport mon  (output low_volt_hit, output high_volt_hit, output high_curr_hit,
		output zero_miss);
	modport core (input low_volt_hit, input high_volt_hit, input high_curr_hit,
		input zero_miss);
endinterface

// *** logic/mif_flags_top.sv ***
// Mode register two, interrupt-cause flags, request pin and the per-cycle
// arithmetic that the mode bits steer.
// Assumes metering strobes come from logic on ref_clk; only the supply
// warning arrives from a pin. Mask register lives elsewhere and feeds irq_mask.
`timescale 1ns/1ps
module mif_flags_top
	import mif_pkg::*;
#(
	parameter int CH = 3,
	parameter int W  = 16
) (
	input  wire logic                 ref_clk,
	input  wire logic                 sys_rst,
	input  wire logic [ADDR_W-1:0]    reg_addr,
	input  wire logic                 reg_wr_en,
	input  wire logic [DATA_W-1:0]    reg_wr_data,
	output logic      [DATA_W-1:0]    reg_rd_data,
	input  wire logic [DATA_W-1:0]    irq_mask,
	output logic                      irq_n,
	input  wire logic                 cycle_start,
	input  wire logic                 cycle_done,
	input  wire logic                 energy_away,
	input  wire logic                 accum_wrap,
	input  wire logic [DATA_W-1:0]    config_calibration_sum,
	input  wire logic                 supply_fail_pin,
	input  wire logic                 sample_valid,
	input  wire logic [CH-1:0][W-1:0] volt_abs,
	input  wire logic [CH-1:0][W-1:0] curr_abs,
	input  wire logic [CH-1:0]        zero_cross,
	input  wire logic [W-1:0]         zero_cross_timeout_register,
	input  wire logic [W-1:0]         low_voltage_level_register,
	input  wire logic [W-1:0]         high_voltage_level_register,
	input  wire logic [W-1:0]         high_current_level_register,
	input  wire logic [W-1:0]         rms_voltage_value,
	input  wire logic [W-1:0]         rms_current_value,
	input  wire logic [W-1:0]         current_linearity_correction,
	output logic                      current_offset_method_select,
	output logic [1:0]                wiring_coefficient_select,
	output logic                      apparent_power_method_select,
	output logic [2*W-1:0]            apparent_power,
	output logic                      apparent_power_valid,
	output logic [W-1:0]              corrected_current,
	output logic                      corrected_current_valid
);
	// Saturating add keeps a correction from wrapping to a tiny value
	function automatic logic [2*W-1:0] sat_add(input logic [2*W-1:0] a,
		input logic [2*W-1:0] b, input logic [2*W-1:0] lim);
		logic [2*W:0] s;
		s = {1'b0, a} + {1'b0, b};
		sat_add = (s > {1'b0, lim}) ? lim : s[2*W-1:0];
	endfunction

	localparam logic [2*W-1:0] WIDE_MAX   = '1;
	localparam logic [2*W-1:0] NARROW_MAX = (2*W)'({W{1'b1}});

	mif_evt_if evt ();

	mif_chan_mon #(.CH(CH), .W(W)) u_mon (
		.ref_clk      (ref_clk),
		.sys_rst      (sys_rst),
		.sample_valid (sample_valid),
		.volt_abs     (volt_abs),
		.curr_abs     (curr_abs),
		.low_level    (low_voltage_level_register),
		.high_level   (high_voltage_level_register),
		.curr_level   (high_current_level_register),
		.zero_cross   (zero_cross),
		.cycle_start  (cycle_start),
		.zx_timeout   (zero_cross_timeout_register),
		.evt          (evt.mon)
	);

	// Register state
	logic [7:0]        opcfg2_reg;
	logic [15:0]       flags_reg;
	logic [15:0]       flags_next;
	logic              busy_reg;
	logic              dir_reg;
	logic              dir_seen_reg;
	logic [DATA_W-1:0] sum_reg;
	logic              sum_seen_reg;
	logic              pf_meta_reg;
	logic              pf_sync_reg;
	logic              sq_pend_reg;

	// Decode
	wire               wr_opcfg2   = reg_wr_en && reg_addr == OPCFG2_OFS;
	wire               wr_flags    = reg_wr_en && reg_addr == FLAGS_OFS;
	wire               sel_opcfg2  = reg_addr == OPCFG2_OFS;
	wire               sel_flags   = reg_addr == FLAGS_OFS;
	wire [15:0]        flag_clr    = wr_flags ? reg_wr_data : 16'h0000;
	wire               ofs_method  = opcfg2_reg[OFS_METHOD_BIT];
	wire               app_method  = opcfg2_reg[APP_METHOD_BIT];
	wire               done_eff    = cycle_done;
	// Done and next start in one cycle is on time, not an overrun
	wire               overrun     = cycle_start && busy_reg && !cycle_done;
	wire               dir_change  = cycle_done && dir_seen_reg
		&& energy_away != dir_reg;
	wire               sum_change  = sum_seen_reg
		&& config_calibration_sum != sum_reg;

	// Event vector in flag-bit order
	logic [15:0] flag_set;
	always_comb begin
		flag_set                  = 16'h0000;
		flag_set[OVERRUN_BIT]     = overrun;
		flag_set[CYC_DONE_BIT]    = done_eff;
		flag_set[DIR_CHG_BIT]     = dir_change;
		flag_set[ZX_MISS_BIT]     = evt.zero_miss;
		flag_set[LOW_V_BIT]       = evt.low_volt_hit;
		flag_set[HIGH_V_BIT]      = evt.high_volt_hit;
		flag_set[HIGH_I_BIT]      = evt.high_curr_hit;
		flag_set[ACC_WRAP_BIT]    = accum_wrap;
		flag_set[SUM_CHG_BIT]     = sum_change;
		flag_set[SUPPLY_FAIL_BIT] = pf_sync_reg;
	end

	// Write-one clears; a coincident event wins so nothing is lost
	assign flags_next = ((flags_reg & ~flag_clr) | flag_set)
		& FLAGS_IMPL_MASK;

	// Read path
	wire [15:0] rd_mux = sel_opcfg2 ? {8'h00, opcfg2_reg & OPCFG2_IMPL_MASK}
		: sel_flags ? flags_reg : 16'h0000;

	// Per-cycle arithmetic
	wire [2*W-1:0] rms_current_value_sq   = (2*W)'(rms_current_value) * (2*W)'(rms_current_value);
	wire [2*W-1:0] sq_input  = sat_add(rms_current_value_sq, (2*W)'(current_linearity_correction),
		WIDE_MAX);
	wire [2*W-1:0] lin_sum   = sat_add((2*W)'(rms_current_value),
		(2*W)'(current_linearity_correction), NARROW_MAX);
	wire [2*W-1:0] app_prod  = (2*W)'(rms_voltage_value) * (2*W)'(rms_current_value);
	wire           sq_start  = cycle_done && !ofs_method;
	wire [W-1:0]   sq_root;
	wire           sq_done;

	mif_isqrt #(.W(W)) u_sqrt (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.start    (sq_start),
		.radicand (sq_input),
		.root     (sq_root),
		.done     (sq_done)
	);

	// Mode register
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			opcfg2_reg <= OPCFG2_RST;
		else if (wr_opcfg2)
			opcfg2_reg <= reg_wr_data[7:0] & OPCFG2_IMPL_MASK;
	end

	// Mode fields out to the power datapath
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			current_offset_method_select <= 1'b0;
			wiring_coefficient_select    <= WIRE_UNITY;
			apparent_power_method_select <= 1'b0;
		end else begin
			current_offset_method_select <= ofs_method;
			wiring_coefficient_select    <= opcfg2_reg[WIRING_HI:WIRING_LO];
			apparent_power_method_select <= app_method;
		end
	end

	// Flags and request pin
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			flags_reg <= FLAGS_RST;
			irq_n     <= 1'b1;
		end else begin
			flags_reg <= flags_next;
			// Pin drops with the flag itself, no extra cycle
			irq_n     <= ~|(flags_next & irq_mask);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			reg_rd_data <= 16'h0000;
		else
			reg_rd_data <= rd_mux;
	end

	// Cycle tracking
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			busy_reg <= 1'b0;
		else if (cycle_start)
			busy_reg <= 1'b1;
		else if (cycle_done)
			busy_reg <= 1'b0;
	end

	// Direction history; first finished cycle only records
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			dir_reg      <= 1'b0;
			dir_seen_reg <= 1'b0;
		end else if (cycle_done) begin
			dir_reg      <= energy_away;
			dir_seen_reg <= 1'b1;
		end
	end

	// Checksum history; value after reset is the baseline
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sum_reg      <= '0;
			sum_seen_reg <= 1'b0;
		end else begin
			sum_reg      <= config_calibration_sum;
			sum_seen_reg <= 1'b1;
		end
	end

	// Supply warning pin is asynchronous
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pf_meta_reg <= 1'b0;
			pf_sync_reg <= 1'b0;
		end else begin
			pf_meta_reg <= supply_fail_pin;
			pf_sync_reg <= pf_meta_reg;
		end
	end

	// Apparent power once per cycle; the other method setting is unsupported
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			apparent_power       <= '0;
			apparent_power_valid <= 1'b0;
		end else begin
			apparent_power_valid <= cycle_done && !app_method;
			if (cycle_done && !app_method)
				apparent_power <= app_prod;
		end
	end

	// Offset-corrected current; root form takes W+1 extra cycles
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			corrected_current       <= '0;
			corrected_current_valid <= 1'b0;
			sq_pend_reg             <= 1'b0;
		end else begin
			corrected_current_valid <= 1'b0;
			if (sq_start)
				sq_pend_reg <= 1'b1;
			if (cycle_done && ofs_method) begin
				corrected_current       <= lin_sum[W-1:0];
				corrected_current_valid <= 1'b1;
			end else if (sq_done && sq_pend_reg) begin
				corrected_current       <= sq_root;
				corrected_current_valid <= 1'b1;
				sq_pend_reg             <= 1'b0;
			end
		end
	end
endmodule // mif_flags_top

// *** logic/mif_isqrt.sv ***
// Bit-serial integer square root, one result bit per clock.
// Assumes start is a pulse on ref_clk and is ignored while busy.
`timescale 1ns/1ps
module mif_isqrt
	import mif_pkg::*;
#(
	parameter int W = 16
) (
	input  wire logic           ref_clk,
	input  wire logic           sys_rst,
	input  wire logic           start,
	input  wire logic [2*W-1:0] radicand,
	output logic      [W-1:0]   root,
	output logic                done
);
	mif_sq_state_e      state_reg;
	logic [2*W-1:0]     rad_reg;
	logic [W-1:0]       root_reg;
	logic [$clog2(W):0] bit_reg;
	logic [W-1:0]       trial;
	logic               keep;

	assign trial = root_reg | (W'(1) << bit_reg[$clog2(W)-1:0]);
	assign keep  = (2*W)'(trial) * (2*W)'(trial) <= rad_reg;
	assign root  = root_reg;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_reg <= SQ_IDLE;
			rad_reg   <= '0;
			root_reg  <= '0;
			bit_reg   <= '0;
			done      <= 1'b0;
		end else begin
			done <= 1'b0;
			unique case (state_reg)
				SQ_IDLE: if (start) begin
					state_reg <= SQ_RUN;
					rad_reg   <= radicand;
					root_reg  <= '0;
					bit_reg   <= ($clog2(W)+1)'(W - 1);
				end
				SQ_RUN: begin
					if (keep)
						root_reg <= trial;
					// Last bit decided: result valid next cycle
					if (bit_reg == '0) begin
						state_reg <= SQ_IDLE;
						done      <= 1'b1;
					end else begin
						bit_reg <= bit_reg - 1'b1;
					end
				end
			endcase
		end
	end
endmodule // mif_isqrt

// *** logic/mif_pkg.sv ***
// Constants, field layout and types for the mode and interrupt-cause block.
// Assumes every user sits in the ref_clk domain and imports this package whole.
// How it works
// - Mode bit 3 picks offset correction form
// - Two-bit wiring field picks power coefficient
// - Method zero: apparent power equals Vrms times Rms_current_value
// - Flag register shows which events raised request
// - Bit 15 set on processing overrun
// - Bit 14 set when processing cycle completes
// - Bit 12 set on energy direction reversal
// - Bit 11 set on zero-cross timeout
// - Bit 10 set when voltage stays low
// - Bit 9 set on voltage above trip
// - Bit 8 set on current above trip
// - Bit 2 set on accumulator overflow
// - Bit 1 set when configuration checksum changes
// - Bit 0 set on imminent supply failure
// - Request pin follows only enabled flags
package mif_pkg;
	localparam int              ADDR_W           = 10;
	localparam int              DATA_W           = 16;
	localparam logic [9:0]      OPCFG2_OFS       = 10'h003;
	localparam logic [9:0]      FLAGS_OFS        = 10'h004;
	localparam logic [7:0]      OPCFG2_RST       = 8'h00;
	localparam logic [7:0]      OPCFG2_IMPL_MASK = 8'h0f;
	localparam logic [15:0]     FLAGS_RST        = 16'h0000;
	localparam logic [15:0]     FLAGS_IMPL_MASK  = 16'hdf07;
	localparam int              OFS_METHOD_BIT   = 3;
	localparam int              WIRING_HI        = 2;
	localparam int              WIRING_LO        = 1;
	localparam int              APP_METHOD_BIT   = 0;
	localparam int              OVERRUN_BIT      = 15;
	localparam int              CYC_DONE_BIT     = 14;
	localparam int              DIR_CHG_BIT      = 12;
	localparam int              ZX_MISS_BIT      = 11;
	localparam int              LOW_V_BIT        = 10;
	localparam int              HIGH_V_BIT       = 9;
	localparam int              HIGH_I_BIT       = 8;
	localparam int              ACC_WRAP_BIT     = 2;
	localparam int              SUM_CHG_BIT      = 1;
	localparam int              SUPPLY_FAIL_BIT  = 0;

	typedef enum logic [1:0] {
		WIRE_UNITY         = 2'b00,
		WIRE_THREE_PH_3W   = 2'b01,
		WIRE_THREE_V_THREE_I = 2'b10,
		WIRE_RESERVED      = 2'b11
	} mif_wiring_e;

	typedef enum logic {
		SQ_IDLE = 1'b0,
		SQ_RUN  = 1'b1
	} mif_sq_state_e;
endpackage

// *** test/mif_flags_sva.sv ***
// Checker for the mode register, cause flags and request pin of the flags top.
// Assumes one ref_clk domain and a synchronous active-high sys_rst.
`timescale 1ns/1ps
module mif_flags_sva
	import mif_pkg::*;
#(
	parameter int W = 16
) (
	input wire logic              ref_clk,
	input wire logic              sys_rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic              reg_wr_en,
	input wire logic [DATA_W-1:0] reg_rd_data,
	input wire logic [DATA_W-1:0] irq_mask,
	input wire logic              irq_n,
	input wire logic              cycle_done,
	input wire logic              accum_wrap,
	input wire logic              supply_fail_pin,
	input wire logic [W-1:0]      rms_voltage_value,
	input wire logic [W-1:0]      rms_current_value,
	input wire logic [W-1:0]      current_linearity_correction,
	input wire logic              current_offset_method_select,
	input wire logic [1:0]        wiring_coefficient_select,
	input wire logic              apparent_power_method_select,
	input wire logic [2*W-1:0]    apparent_power,
	input wire logic              apparent_power_valid,
	input wire logic [W-1:0]      corrected_current,
	input wire logic              corrected_current_valid
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	// Extra bit keeps the carry that decides saturation
	logic [W:0] lin_sum;
	assign lin_sum = rms_current_value + current_linearity_correction;

	mode_mirror_a: assert property (reg_addr == OPCFG2_OFS |=>
		reg_rd_data == {12'h000, current_offset_method_select, wiring_coefficient_select,
		apparent_power_method_select}) else $error("mode readback differs from mode outputs");
	flag_rsvd_a: assert property (reg_addr == FLAGS_OFS |=>
		(reg_rd_data & ~FLAGS_IMPL_MASK) == 16'h0000) else $error("reserved flag bit set");
	unmapped_zero_a: assert property (reg_addr != OPCFG2_OFS && reg_addr != FLAGS_OFS
		|=> reg_rd_data == 16'h0000) else $error("unmapped read not zero");
	done_irq_a: assert property (cycle_done && irq_mask[CYC_DONE_BIT] |=> !irq_n)
		else $error("cycle done did not raise request");
	wrap_irq_a: assert property (accum_wrap && irq_mask[ACC_WRAP_BIT] |=> !irq_n)
		else $error("accumulator wrap did not raise request");
	supply_irq_a: assert property ($rose(supply_fail_pin) && irq_mask[SUPPLY_FAIL_BIT]
		##1 supply_fail_pin[*2] |-> ##[1:2] !irq_n) else $error("supply warning missing");
	quiet_mask_a: assert property (irq_mask == 16'h0000 |=> irq_n)
		else $error("request with all enables off");
	sticky_irq_a: assert property (!irq_n && $stable(irq_mask) &&
		!(reg_wr_en && reg_addr == FLAGS_OFS) |=> !irq_n) else $error("request dropped alone");
	app_power_a: assert property (cycle_done && !apparent_power_method_select |=>
		apparent_power_valid && apparent_power == $past(rms_voltage_value) *
		$past(rms_current_value)) else $error("apparent power wrong");
	lin_corr_a: assert property (cycle_done && current_offset_method_select |=>
		corrected_current_valid && corrected_current ==
		($past(lin_sum[W]) ? 16'hffff : $past(lin_sum[W-1:0]))) else $error("linear sum wrong");
	sqrt_time_a: assert property (cycle_done && !current_offset_method_select |->
		##18 corrected_current_valid) else $error("root result late or missing");
endmodule // mif_flags_sva

bind mif_flags_top mif_flags_sva #(.W(W)) i_sva (.*);

// *** test/mif_host_model.sv ***
// Host model: drives the register port and the external enable mask.
// Assumes ref_clk from the bench; requests change just after a rising edge.
`timescale 1ns/1ps
module mif_host_model
	import mif_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic [DATA_W-1:0] reg_rd_data,
	output logic      [ADDR_W-1:0] reg_addr,
	output logic                   reg_wr_en,
	output logic      [DATA_W-1:0] reg_wr_data,
	output logic      [DATA_W-1:0] irq_mask
);
	initial begin
		reg_addr = 10'h000;
		reg_wr_en = 1'b0;
		reg_wr_data = 16'h0000;
		irq_mask = 16'h0000;
	end
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wr_en <= 1'b1;
		reg_wr_data <= (a == OPCFG2_OFS) ? (d & 16'hfffe) : d;
		@(posedge ref_clk);
		reg_wr_en <= 1'b0;
	endtask
	// Address set one edge ahead so the registered answer is settled
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		@(posedge ref_clk);
		#1 d = reg_rd_data;
	endtask
	task automatic clr(input logic [DATA_W-1:0] m);
		wr(FLAGS_OFS, m);
	endtask
	task automatic setm(input logic [DATA_W-1:0] m);
		@(posedge ref_clk);
		irq_mask <= m;
	endtask
endmodule // mif_host_model

// *** test/test_metering_mode_and_irq_flags.sv ***
// Self-checking bench for the mode register and interrupt-cause flags.
// Assumes the host model on the register port and metering strobes from here.
`timescale 1ns/1ps
module test_metering_mode_and_irq_flags
	import mif_pkg::*;
;
	localparam logic [2:0][15:0] MID_V = {3{16'h4000}};
	localparam logic [2:0][15:0] CUR_OK = {3{16'h1000}};
	localparam logic [15:0] EXP [10] = '{
		16'h0004,
		16'h0001,
		16'h0002,
		16'h0200,
		16'h0100,
		16'h5000,
		16'h4400,
		16'hc000,
		16'h4800,
		16'h5000};
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [9:0] reg_addr;
	logic reg_wr_en;
	logic [15:0] reg_wr_data, reg_rd_data, irq_mask, got, d, m;
	logic irq_n, current_offset_method_select, apparent_power_method_select;
	logic cycle_start = 1'b0, cycle_done = 1'b0, energy_away = 1'b0, accum_wrap = 1'b0;
	logic supply_fail_pin = 1'b0, sample_valid = 1'b0, apparent_power_valid;
	logic corrected_current_valid;
	logic [1:0] wiring_coefficient_select;
	logic [15:0] config_calibration_sum = 16'h1234, zero_cross_timeout_register = 16'h0000;
	logic [15:0] low_voltage_level_register = 16'h1000, high_voltage_level_register = 16'h8000;
	logic [15:0] high_current_level_register = 16'h8000, corrected_current;
	logic [15:0] rms_voltage_value = 16'h0000, rms_current_value = 16'h0000;
	logic [15:0] current_linearity_correction = 16'h0000;
	logic [2:0][15:0] volt_abs = MID_V, curr_abs = CUR_OK;
	logic [2:0] zero_cross = 3'b000;
	logic [31:0] apparent_power;
	int seed = 32'h5a2b;
	int n_mismatch = 0;
	int check_count = 0;

	always #10 ref_clk = ~ref_clk;

	mif_flags_top i_dut (.*);
	mif_host_model i_host (.*);

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [15:0] exp_cur(input logic lin, input logic [15:0] a, b);
		logic [63:0] x;
		logic [31:0] r;
		x = lin ? 64'(a) + 64'(b) : 64'(a) * 64'(a) + 64'(b);
		if (lin)
			return (x > 64'hffff) ? 16'hffff : x[15:0];
		r = 32'h0;
		for (int k = 15; k >= 0; k--)
			if (64'(r | (32'h1 << k)) * 64'(r | (32'h1 << k)) <= x)
				r = r | (32'h1 << k);
		return r[15:0];
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic pulse(input int k);
		@(posedge ref_clk);
		case (k)
			0: cycle_start <= 1'b1;
			1: cycle_done <= 1'b1;
			default: accum_wrap <= 1'b1;
		endcase
		@(posedge ref_clk);
		cycle_start <= 1'b0;
		cycle_done <= 1'b0;
		accum_wrap <= 1'b0;
	endtask
	task automatic feed(input logic [2:0][15:0] v, input logic [2:0][15:0] c);
		@(posedge ref_clk);
		volt_abs <= v;
		curr_abs <= c;
		sample_valid <= 1'b1;
		@(posedge ref_clk);
		sample_valid <= 1'b0;
	endtask
	// More than one start before done is an overrun on purpose
	task automatic cycle(input int n, input logic [2:0][15:0] v);
		repeat (n) begin
			feed(v, CUR_OK);
			pulse(0);
		end
		pulse(1);
		tick(20);
	endtask
	task automatic kick(input int k, input int ch);
		logic [2:0][15:0] v;
		v = MID_V;
		@(posedge ref_clk);
		case (k)
			0: pulse(2);
			1: begin
				supply_fail_pin <= 1'b1;
				tick(4);
				supply_fail_pin <= 1'b0;
			end
			2: config_calibration_sum <= config_calibration_sum + 16'h0101;
			3: begin
				v[ch] = 16'h9000;
				feed(v, CUR_OK);
			end
			4: begin
				v[ch] = 16'h9000;
				feed(MID_V, v);
			end
			// Second visit reverses the flow back toward the load
			5, 9: begin
				energy_away <= ~energy_away;
				cycle(1, MID_V);
			end
			6: begin
				v[ch] = 16'h0800;
				cycle(1, v);
			end
			7: cycle(2, MID_V);
			default: begin
				zero_cross <= 3'b111;
				zero_cross_timeout_register <= 16'h0002;
				@(posedge ref_clk);
				zero_cross <= 3'b000;
				repeat (3) cycle(1, MID_V);
				zero_cross_timeout_register <= 16'h0000;
			end
		endcase
	endtask

	initial begin
		repeat (30000) @(posedge ref_clk);
		n_mismatch++;
		final_report();
	end

	initial begin
		tick(3);
		sys_rst <= 1'b0;
		i_host.rd(OPCFG2_OFS, got);
		chk("mode reset", OPCFG2_RST, got);
		i_host.rd(FLAGS_OFS, got);
		chk("flags reset", FLAGS_RST, got);
		chk("irq_n reset", 1'b1, irq_n);
		for (int i = 0; i < 4; i++) begin
			d = 16'($random(seed));
			d[3:1] = {i[0], i[1:0]};
			i_host.wr(OPCFG2_OFS, d);
			i_host.rd(OPCFG2_OFS, got);
			chk("mode", d & 16'h000e, got);
			chk("wiring", i[1:0], wiring_coefficient_select);
			rms_voltage_value <= (i == 3) ? 16'hffff : 16'($random(seed));
			rms_current_value <= (i == 3) ? 16'hffff : 16'($random(seed));
			current_linearity_correction <= (i == 3) ? 16'hffff : 16'($random(seed));
			cycle(1, MID_V);
			chk("power", 32'(rms_voltage_value) * 32'(rms_current_value), apparent_power);
			got = exp_cur(d[3], rms_current_value, current_linearity_correction);
			chk("current", got, corrected_current);
		end
		i_host.wr(10'h3f5 | 10'($random(seed)), 16'hffff);
		i_host.rd(10'h010 | 10'($random(seed)), got);
		chk("unmapped", 16'h0000, got);
		i_host.rd(OPCFG2_OFS, got);
		chk("mode kept", d & 16'h000e, got);
		i_host.clr(16'hffff);
		for (int k = 0; k < 10; k++) begin
			m = 16'($random(seed));
			// Enables forced on where a checker needs the request to fire
			if (k < 2 || k == 5)
				m = m | EXP[k];
			i_host.setm(m);
			kick(k, {$random(seed)} % 3);
			tick(4);
			i_host.rd(FLAGS_OFS, got);
			chk("flags", EXP[k], got);
			chk("irq_n", !(|(EXP[k] & m)), irq_n);
			i_host.clr(EXP[k]);
			i_host.rd(FLAGS_OFS, got);
			chk("cleared", 16'h0000, got);
		end
		final_report();
	end
endmodule // test_metering_mode_and_irq_flags
